/* File: design/dcdcc_div.v */
// Divider that turns the system clock into a converter clock enable pulse.
// Assumes clk_sys is the only clock and the code input is stable per cycle.
`timescale 1ns/1ps

module dcdcc_div #(
  parameter CNT_W = 3
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Control
  input wire run,
  input wire [1:0] div_code,
  input wire invert,
  // Result
  output reg tick_r
);

  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] last;
  reg [CNT_W-1:0] fire_at;

  // Codes 0..3 give terminal counts 0, 1, 3 and 7.
  always @* begin
    last = (({{(CNT_W-1){1'b0}}, 1'b1} << div_code) - {{(CNT_W-1){1'b0}}, 1'b1});
    // An inverted source clock moves the edge by half a divided period; code 0 has no shift.
    fire_at = invert ? (last >> 1) + {{(CNT_W-1){1'b0}}, (last != {CNT_W{1'b0}})} : {CNT_W{1'b0}};
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {CNT_W{1'b0}};
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= {CNT_W{1'b0}};
      tick_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r >= last) ? {CNT_W{1'b0}} : cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      tick_r <= (cnt_r == fire_at);
    end
  end

endmodule // dcdcc_div

/* File: design/dcdcc_regs.vh */
// Register map, field positions, reset values and timing counts of the
// converter clock control block.
// Assumes a 125 MHz system clock and one APB slave per block.
`ifndef DCDCC_REGS_VH
`define DCDCC_REGS_VH

// ----------------------------------------------------------------------
// Register index and byte address
// ----------------------------------------------------------------------
`define DCDCC_CTRL_IDX 12'h097
`define DCDCC_CTRL_ADDR 12'h25C
`define DCDCC_CTRL_RESET 8'h03

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DCDCC_SRC_BIT 7
`define DCDCC_DIV_HI 6
`define DCDCC_DIV_LO 5
`define DCDCC_SARPOL_BIT 4
`define DCDCC_INV_BIT 3
`define DCDCC_SYNC_BIT 2
`define DCDCC_MIN_PULSE_WIDTH_SEL_HI 1
`define DCDCC_MIN_PULSE_WIDTH_SEL_LO 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DCDCC_CLK_PERIOD_NS 8
`define DCDCC_MINPW1_NS 10
`define DCDCC_MINPW2_NS 20
`define DCDCC_MINPW3_NS 40
`define DCDCC_NS_TO_CYC(ns) (((ns) + `DCDCC_CLK_PERIOD_NS - 1) / `DCDCC_CLK_PERIOD_NS)

`endif

/* File: design/dcdcc_top.v */
// Converter clock and ADC synchronisation control with one APB register.
// Assumes a single 125 MHz clock; the local oscillator arrives asynchronously.
`timescale 1ns/1ps
`include "dcdcc_regs.vh"

module dcdcc_top (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Local oscillator pin
  input wire osc_local,
  // Converter switcher side
  output reg conv_tick_r,
  output reg conv_clk_r,
  output reg min_pulse_width_sel_en_r,
  output reg [2:0] min_pulse_width_sel_cycles_r,
  // ADC side
  output reg adc_sync_r,
  output reg adc_track_r,
  output reg sar_clk_r
);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  reg [7:0] ctrl_r;
  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire addr_hit = (paddr == `DCDCC_CTRL_ADDR);
  // Bit 7 is writable so that software can choose the converter clock source.
  wire wr_en = apb_access && pwrite && addr_hit;
  wire [31:0] rd_word = addr_hit ? {24'h000000, ctrl_r} : 32'h00000000;

  // The slave never stalls; a stray address answers with an error and has no effect.
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_hit;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `DCDCC_CTRL_RESET;
    end else if (wr_en) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // Read data is registered during setup so it is valid in the access phase.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  // Fields act from the cycle after the write edge.
  wire src_sys = ctrl_r[`DCDCC_SRC_BIT];
  wire [1:0] div_code = ctrl_r[`DCDCC_DIV_HI:`DCDCC_DIV_LO];
  wire sar_pol = ctrl_r[`DCDCC_SARPOL_BIT];
  wire sys_inv = ctrl_r[`DCDCC_INV_BIT];
  wire sync_en = ctrl_r[`DCDCC_SYNC_BIT];
  wire [1:0] min_pulse_width_sel = ctrl_r[`DCDCC_MIN_PULSE_WIDTH_SEL_HI:`DCDCC_MIN_PULSE_WIDTH_SEL_LO];

  // ----------------------------------------------------------------------
  // Local oscillator synchroniser and edge detect
  // ----------------------------------------------------------------------
  reg osc_s1_r;
  reg osc_s2_r;
  reg osc_s3_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_local;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // Only the second and third flops feed logic; the first may still be settling.
  // The third flop only remembers the previous level for the edge detect.
  wire osc_rise = osc_s2_r && !osc_s3_r;

  // ----------------------------------------------------------------------
  // System clock divider
  // ----------------------------------------------------------------------
  // The divider is held cleared while the local oscillator is selected, so a
  // switch to the system clock always starts from a known phase.
  wire sys_tick;

  dcdcc_div #(
    .CNT_W(3)
  ) u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(src_sys),
    .div_code(div_code),
    .invert(sys_inv),
    .tick_r(sys_tick)
  );

  // ----------------------------------------------------------------------
  // Converter clock selection
  // ----------------------------------------------------------------------
  wire conv_tick_nxt = src_sys ? sys_tick : osc_rise;
  // The converter clock is a square wave at half the tick rate; each tick is one of its edges.
  wire conv_clk_nxt = conv_tick_nxt ? !conv_clk_r : conv_clk_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conv_tick_r <= 1'b0;
    end else begin
      conv_tick_r <= conv_tick_nxt;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conv_clk_r <= 1'b0;
    end else begin
      conv_clk_r <= conv_clk_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Minimum pulse width
  // ----------------------------------------------------------------------
  // Widths are rounded up to whole system clock cycles, so a pulse is never shorter than asked.
  wire [31:0] minpw1_full = `DCDCC_NS_TO_CYC(`DCDCC_MINPW1_NS);
  wire [31:0] minpw2_full = `DCDCC_NS_TO_CYC(`DCDCC_MINPW2_NS);
  wire [31:0] minpw3_full = `DCDCC_NS_TO_CYC(`DCDCC_MINPW3_NS);
  reg [2:0] min_pulse_width_sel_cycles_nxt;

  always @* begin
    case (min_pulse_width_sel)
      2'b01: begin
        min_pulse_width_sel_cycles_nxt = minpw1_full[2:0];
      end
      2'b10: begin
        min_pulse_width_sel_cycles_nxt = minpw2_full[2:0];
      end
      2'b11: begin
        min_pulse_width_sel_cycles_nxt = minpw3_full[2:0];
      end
      default: begin
        min_pulse_width_sel_cycles_nxt = 3'h0;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      min_pulse_width_sel_en_r <= 1'b0;
    end else begin
      min_pulse_width_sel_en_r <= (min_pulse_width_sel != 2'b00);
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      min_pulse_width_sel_cycles_r <= 3'h0;
    end else begin
      min_pulse_width_sel_cycles_r <= min_pulse_width_sel_cycles_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // ADC synchronisation
  // ----------------------------------------------------------------------
  // Tracking runs while the converter clock is low, the equal-length quiet half of
  // the switching cycle; SAR clock follows the converter clock when the polarity bit is set and is its inverse when clear.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adc_sync_r <= 1'b0;
    end else begin
      adc_sync_r <= sync_en;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adc_track_r <= 1'b0;
    end else begin
      adc_track_r <= sync_en && !conv_clk_nxt;
    end
  end

  // Polarity only matters while sync is on; with sync off the SAR clock rests low.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sar_clk_r <= 1'b0;
    end else if (sync_en) begin
      sar_clk_r <= conv_clk_nxt ^ !sar_pol;
    end else begin
      sar_clk_r <= 1'b0;
    end
  end

endmodule // dcdcc_top

/* File: dv/dcdc_clock_sync_control_tb_top.sv */
// Bench for the converter clock control block.
// Drives APB and the local oscillator; checks converter and ADC outputs.
`timescale 1ns/1ps
module dcdc_clock_sync_control_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] half_ns = 8'h28;
  wire pready, pslverr, osc_local, conv_tick_r, conv_clk_r, min_pulse_width_sel_en_r, adc_sync_r, adc_track_r, sar_clk_r;
  wire [31:0] prdata;
  wire [2:0] min_pulse_width_sel_cycles_r;
  localparam logic [2:0] MP [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
  int fail_count = 0;
  int comparisons = 0;
  int g;
  int lat0;
  logic [32:0] exp_q[$];
  always #4 clk_sys = ~clk_sys;
  dcdcc_top dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .osc_local, .conv_tick_r, .conv_clk_r, .min_pulse_width_sel_en_r, .min_pulse_width_sel_cycles_r, .adc_sync_r, .adc_track_r, .sar_clk_r);
  dcdcc_osc_model osc (.half_ns, .osc_local);
  task chk(input string n, input logic [32:0] s, input logic [32:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  task gap;
    @(posedge clk_sys iff conv_tick_r);
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (!conv_tick_r);
  endtask
  // Counts edges after a write until the first tick; the first edge still shows the old source.
  task first_tick;
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (g < 2 || !conv_tick_r);
  endtask
  task give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Read results are compared in the cycle the access completes.
  always @(posedge clk_sys) if (psel && penable && pready === 1'b1 && !pwrite) chk("read", {pslverr, prdata}, exp_q.pop_front());
  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end
  initial begin
    logic [7:0] c;
    void'($urandom(15));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(12'h25C, 33'h000000003);
    chk("min_pulse_width_sel reset", min_pulse_width_sel_cycles_r, 3'h5);
    rd(12'h004, 33'h100000000);
    $display("reset and map test done");
    for (int d = 0; d < 4; d++) begin
      c = {1'b1, d[1:0], 1'b0, 1'($urandom), 3'b011};
      apb(1'b1, 12'h25C, c);
      rd(12'h25C, {25'h0000000, c});
      gap;
      gap;
      chk("tick gap", g, 1 << d);
    end
    // Inversion delays the first divided tick by half a divided period.
    for (int d = 1; d < 4; d++) begin
      for (int v = 0; v < 2; v++) begin
        apb(1'b1, 12'h25C, {1'b0, d[1:0], 5'b00011});
        apb(1'b1, 12'h25C, {1'b1, d[1:0], 1'b0, v[0], 3'b011});
        first_tick;
        if (v == 0) lat0 = g;
      end
      chk("invert phase", g - lat0, 1 << (d - 1));
    end
    $display("divider test done");
    apb(1'b1, 12'h25C, 8'h63);
    gap;
    gap;
    chk("osc gap", g, 10);
    half_ns <= 8'h18;
    gap;
    gap;
    gap;
    chk("osc gap", g, 6);
    $display("local source test done");
    for (int p = 0; p < 2; p++) begin
      c = {3'b110, p[0], 4'b0111};
      apb(1'b1, 12'h25C, c);
      repeat (3) @(posedge clk_sys);
      repeat (8) begin
        @(negedge clk_sys);
        chk("sar clk", sar_clk_r, conv_clk_r ^ !p[0]);
        chk("track", adc_track_r, !conv_clk_r);
        chk("sync on", adc_sync_r, 1'b1);
      end
      apb(1'b1, 12'h25C, c & 8'hFB);
      repeat (3) @(negedge clk_sys);
      chk("sync off", {adc_sync_r, adc_track_r, sar_clk_r}, 3'b000);
    end
    $display("sync test done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h25C, {6'h00, m[1:0]});
      repeat (3) @(negedge clk_sys);
      chk("min_pulse_width_sel", {min_pulse_width_sel_en_r, min_pulse_width_sel_cycles_r}, {m != 0, MP[m]});
    end
    $display("min pulse test done");
    give_verdict;
  end
endmodule // dcdc_clock_sync_control_tb_top
bind dcdcc_top dcdcc_monitor mon (.clk_sys, .rst_n, .pready, .prdata, .conv_tick_r, .conv_clk_r, .min_pulse_width_sel_en_r,
  .min_pulse_width_sel_cycles_r, .adc_sync_r, .adc_track_r, .sar_clk_r);

/* File: dv/dcdcc_monitor.sv */
// Port checker for the converter clock control block.
// Bound to dcdcc_top; sees its ports only.
`timescale 1ns/1ps
module dcdcc_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  // Converter and ADC side
  input wire logic conv_tick_r,
  input wire logic conv_clk_r,
  input wire logic min_pulse_width_sel_en_r,
  input wire logic [2:0] min_pulse_width_sel_cycles_r,
  input wire logic adc_sync_r,
  input wire logic adc_track_r,
  input wire logic sar_clk_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  bus_ready_a: assert property (pready) else $error("pready low");
  read_high_a: assert property (prdata[31:8] == 24'h000000) else $error("prdata upper bits set");
  clock_tick_a: assert property ($changed(conv_clk_r) |-> conv_tick_r) else $error("clock moved without tick");
  sar_off_a: assert property (!adc_sync_r [*2] |-> !sar_clk_r) else $error("SAR clock with sync off");
  track_on_a: assert property (adc_sync_r [*2] |-> adc_track_r != conv_clk_r) else $error("track not in low half");
  track_off_a: assert property (!adc_sync_r [*2] |-> !adc_track_r) else $error("track with sync off");
  min_pulse_width_sel_enable_a: assert property (min_pulse_width_sel_en_r == (min_pulse_width_sel_cycles_r != 3'h0)) else $error("min pulse enable wrong");
  min_pulse_width_sel_value_a: assert property (min_pulse_width_sel_cycles_r inside {3'h0, 3'h2, 3'h3, 3'h5}) else $error("min pulse bad");
  cover property (adc_sync_r && sar_clk_r);
  cover property (conv_tick_r ##1 conv_tick_r);
  cover property (!min_pulse_width_sel_en_r);
endmodule // dcdcc_monitor

/* File: dv/dcdcc_osc_model.sv */
// Local oscillator on the converter's far side.
// Half period comes from the bench; it runs free, as a real oscillator does.
`timescale 1ns/1ps
module dcdcc_osc_model (
  // Setting
  input wire logic [7:0] half_ns,
  // Pin
  output logic osc_local
);
  // The first half period starts once the setting has reached the port.
  initial begin
    osc_local = 1'b0;
    #1;
    forever begin
      #(half_ns);
      osc_local = ~osc_local;
    end
  end
endmodule // dcdcc_osc_model
